/* File: design/pse_map_defines.vh */
// constants for the quad mapping, slice access and power allocation logic
// assumes inclusion by bare name from the design files
`ifndef PSE_MAP_DEFINES_VH
`define PSE_MAP_DEFINES_VH
`define CH_MAX 48
`define DEV_MAX 4
`define CH_LARGE 6'h0c
`define CH_SMALL 6'h08
`define QUAD_OFFSETS 16
`define SEL_PORT 2'h0
`define SEL_CHA 2'h1
`define SEL_CHB 2'h2
`define CLS_EV_LONG 3'h5
`define CLS_EV_SHORT 3'h2
`define PWR_W 11
`define PWR_C1 11'h028
`define PWR_C2 11'h043
`define PWR_C3 11'h08c
`define PWR_C4 11'h12c
`define PWR_C5 11'h1c2
`define PWR_C6 11'h258
`define PWR_C7 11'h2ee
`define PWR_C8 11'h384
`endif

/* File: design/class_power_lut.v */
// class to source output power allocation, 0.1 W units
// assumes a class code from classification logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "pse_map_defines.vh"
module class_power_lut (
  input wire [3:0] class_code,
  output reg [`PWR_W-1:0] power
);
  always @* begin
    case (class_code)
      4'h1: power = `PWR_C1;
      4'h2: power = `PWR_C2;
      4'h3: power = `PWR_C3;
      4'h4: power = `PWR_C4;
      4'h5: power = `PWR_C5;
      4'h6: power = `PWR_C6;
      4'h7: power = `PWR_C7;
      4'h8: power = `PWR_C8;
      default: power = {`PWR_W{1'b0}};
    endcase
  end
endmodule
`default_nettype wire

/* File: design/pse_port_config_map.v */
// port configuration, quad address map, per-port slices and power budget
// assumes cfg_pin is an asynchronous strap; other inputs are sys_clk logic
`timescale 1ns/1ps
`default_nettype none
`include "pse_map_defines.vh"
module pse_port_config_map #(
  parameter NUM_CH = `CH_MAX,
  parameter NUM_DEV = `DEV_MAX
) (
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [2:0] cfg_pin,
  input wire [NUM_DEV-1:0] dev_present,
  input wire [NUM_DEV-1:0] dev_large,
  input wire slice_wr,
  input wire slice_rd,
  input wire slice_pb,
  input wire [3:0] slice_quad,
  input wire [1:0] slice_port,
  input wire [1:0] slice_sel,
  input wire [7:0] slice_wdata,
  input wire [NUM_CH-1:0] chan_pwr_good,
  input wire type34_en,
  input wire budget_req,
  input wire budget_dual,
  input wire [3:0] class_a,
  input wire [3:0] class_b,
  input wire ac_valid,
  input wire [`PWR_W-1:0] ac_meas,
  output reg map_locked_ff,
  output reg four_pair_quad_ff,
  output reg [2:0] cfg_code_ff,
  output reg [2:0] dev_count_ff,
  output reg [5:0] chan_count_ff,
  output reg [5:0] port_count_ff,
  output reg [`QUAD_OFFSETS-1:0] quad_used_ff,
  output reg cfg_err_ff,
  output reg [7:0] rd_data_ff,
  output reg rd_valid_ff,
  output reg rd_miss_ff,
  output reg [NUM_CH*8-1:0] chan_ctl_ff,
  output reg [NUM_CH-1:0] pb_on_ff,
  output reg long_first_ff,
  output reg [2:0] class_ev_max_ff,
  output reg [`PWR_W-1:0] budget_ff,
  output reg budget_valid_ff,
  output reg [`PWR_W-1:0] ac_max_ff,
  output reg [`PWR_W-1:0] ac_reclaim_ff
);
  reg [2:0] cfg_s1_ff;
  reg [2:0] cfg_s2_ff;
  reg [2:0] cfg_s3_ff;
  reg [2:0] nxt_dev_count;
  reg [5:0] nxt_chan_count;
  reg [5:0] nxt_port_count;
  reg [3:0] nxt_quads;
  reg [`QUAD_OFFSETS-1:0] nxt_quad_used;
  reg [3:0] quad_count_ff;
  integer i;
  wire [3:0] q_index;
  wire [5:0] port_idx;
  wire [5:0] ch_a;
  wire [5:0] ch_b;
  wire addr_ok;
  wire [`PWR_W-1:0] pwr_a;
  wire [`PWR_W-1:0] pwr_b;
  wire [`PWR_W-1:0] nxt_budget;
  wire cfg_stable;

  // three-stage strap synchroniser; only stages two and three are compared
  // clk_en low freezes the stages too, so a strap change is seen late, not lost
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s1_ff <= 3'h0;
      cfg_s2_ff <= 3'h0;
      cfg_s3_ff <= 3'h0;
    end else if (clk_en) begin
      cfg_s1_ff <= cfg_pin;
      cfg_s2_ff <= cfg_s1_ff;
      cfg_s3_ff <= cfg_s2_ff;
    end
  end
  assign cfg_stable = (cfg_s2_ff == cfg_s3_ff);

  // capture sequencer: stage reset values must never be taken for the strap
  localparam [4:0] ST_EMPTY = 5'b00001;
  localparam [4:0] ST_ONE = 5'b00010;
  localparam [4:0] ST_TWO = 5'b00100;
  localparam [4:0] ST_FULL = 5'b01000;
  localparam [4:0] ST_DONE = 5'b10000;
  reg [4:0] cap_state_ff;
  reg [4:0] nxt_cap_state;
  wire cap_now;

  always @* begin
    case (cap_state_ff)
      ST_EMPTY: nxt_cap_state = ST_ONE;
      ST_ONE: nxt_cap_state = ST_TWO;
      ST_TWO: nxt_cap_state = ST_FULL;
      // an unsettled strap keeps the map unlocked; slices stay refused meanwhile
      ST_FULL: nxt_cap_state = cfg_stable ? ST_DONE : ST_FULL;
      ST_DONE: nxt_cap_state = ST_DONE;
      default: nxt_cap_state = ST_EMPTY;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_state_ff <= ST_EMPTY;
    end else if (clk_en) begin
      cap_state_ff <= nxt_cap_state;
    end
  end
  assign cap_now = clk_en && cap_state_ff == ST_FULL && cfg_stable;

  always @* begin
    nxt_dev_count = 3'h0;
    nxt_chan_count = 6'h00;
    for (i = 0; i < NUM_DEV; i = i + 1) begin
      if (dev_present[i]) begin
        nxt_dev_count = nxt_dev_count + 3'h1;
        nxt_chan_count = nxt_chan_count + (dev_large[i] ? `CH_LARGE : `CH_SMALL);
      end
    end
  end

  // one or two channels per port
  always @* begin
    nxt_port_count = cfg_s3_ff[0] ? {1'b0, nxt_chan_count[5:1]} : nxt_chan_count;
    nxt_quads = nxt_port_count[5:2];
  end

  // quads fill offsets in order, skipping every fourth
  always @* begin
    nxt_quad_used = {`QUAD_OFFSETS{1'b0}};
    for (i = 0; i < `QUAD_OFFSETS; i = i + 1) begin
      if (i[1:0] != 2'h3 && (i - i / 4) < nxt_quads)
        nxt_quad_used[i] = 1'b1;
    end
  end

  // low code bit picks the quad kind
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      map_locked_ff <= 1'b0;
      four_pair_quad_ff <= 1'b0;
      cfg_code_ff <= 3'h0;
      dev_count_ff <= 3'h0;
      chan_count_ff <= 6'h00;
      port_count_ff <= 6'h00;
      quad_count_ff <= 4'h0;
      quad_used_ff <= {`QUAD_OFFSETS{1'b0}};
      cfg_err_ff <= 1'b0;
    end else if (cap_now) begin
      map_locked_ff <= 1'b1;
      four_pair_quad_ff <= cfg_s3_ff[0];
      cfg_code_ff <= cfg_s3_ff;
      dev_count_ff <= nxt_dev_count;
      chan_count_ff <= nxt_chan_count;
      // no device attached is a fault
      cfg_err_ff <= (nxt_dev_count == 3'h0);
      port_count_ff <= nxt_port_count;
      quad_count_ff <= nxt_quads;
      quad_used_ff <= nxt_quad_used;
    end
  end

  // the unused fourth offset of each group is squeezed out of the index
  // offset and port select one slice
  assign q_index = slice_quad - {2'h0, slice_quad[3:2]};
  assign addr_ok = map_locked_ff && slice_quad[1:0] != 2'h3 && q_index < quad_count_ff;
  assign port_idx = {q_index, slice_port};
  assign ch_a = four_pair_quad_ff ? {port_idx[4:0], 1'b0} : port_idx;
  assign ch_b = {port_idx[4:0], 1'b1};

  // sel 3 names no field, so it must not write or push either channel
  wire sel_to_a;
  wire sel_to_b;
  assign sel_to_a = slice_sel == `SEL_PORT || slice_sel == `SEL_CHA;
  assign sel_to_b = slice_sel == `SEL_PORT || slice_sel == `SEL_CHB;

  // write and pushbutton share one decode per channel
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c = c + 1) begin : g_ch
      wire hit_a;
      wire hit_b;
      wire wr_hit;
      wire pb_hit;
      assign hit_a = addr_ok && ch_a == c;
      assign hit_b = addr_ok && four_pair_quad_ff && ch_b == c;
      assign wr_hit = (hit_a && sel_to_a) || (hit_b && sel_to_b);
      assign pb_hit = slice_pb && wr_hit;
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          chan_ctl_ff[c*8 +: 8] <= 8'h00;
          pb_on_ff[c] <= 1'b0;
        end else if (clk_en) begin
          if (slice_wr && wr_hit)
            chan_ctl_ff[c*8 +: 8] <= slice_wdata;
          pb_on_ff[c] <= pb_hit;
        end
      end
    end
  endgenerate

  // byte is registered, so rd_data_ff holds until the next read
  // three status copies
  reg [7:0] nxt_rd;
  always @* begin
    nxt_rd = 8'h00;
    if (addr_ok) begin
      case (slice_sel)
        `SEL_PORT: nxt_rd = {chan_pwr_good[ch_a] | (four_pair_quad_ff & chan_pwr_good[ch_b]),
                             chan_ctl_ff[ch_a*8 +: 7]};
        `SEL_CHA: nxt_rd = {chan_pwr_good[ch_a], chan_ctl_ff[ch_a*8 +: 7]};
        // channel B reads zero in two-pair
        `SEL_CHB: nxt_rd = four_pair_quad_ff ? {chan_pwr_good[ch_b], chan_ctl_ff[ch_b*8 +: 7]} : 8'h00;
        default: nxt_rd = 8'h00;
      endcase
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
      rd_miss_ff <= 1'b0;
    end else if (clk_en) begin
      rd_valid_ff <= slice_rd;
      rd_miss_ff <= slice_rd && !addr_ok;
      if (slice_rd)
        rd_data_ff <= nxt_rd;
    end
  end

  class_power_lut u_lut_a (
    .class_code(class_a),
    .power(pwr_a)
  );
  class_power_lut u_lut_b (
    .class_code(class_b),
    .power(pwr_b)
  );
  // two class 8 grants still fit the allocation width
  // dual-signature sum
  assign nxt_budget = pwr_a + (budget_dual ? pwr_b : {`PWR_W{1'b0}});

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      budget_ff <= {`PWR_W{1'b0}};
      budget_valid_ff <= 1'b0;
      ac_max_ff <= {`PWR_W{1'b0}};
      ac_reclaim_ff <= {`PWR_W{1'b0}};
      long_first_ff <= 1'b0;
      class_ev_max_ff <= `CLS_EV_SHORT;
    end else if (clk_en) begin
      budget_valid_ff <= budget_req;
      if (budget_req)
        budget_ff <= nxt_budget;
      // reclaim uses the budget held before this edge
      // autoclass measurement and reclaim
      if (ac_valid) begin
        ac_max_ff <= ac_meas;
        ac_reclaim_ff <= (budget_ff > ac_meas) ? budget_ff - ac_meas : {`PWR_W{1'b0}};
      end
      // long first event for type 3 or 4
      long_first_ff <= type34_en;
      class_ev_max_ff <= type34_en ? `CLS_EV_LONG : `CLS_EV_SHORT;
    end
  end
endmodule
`default_nettype wire

/* File: verif/pse_map_monitor.sv */
// assertions on the port map block outputs
// assumes clk_en only drops while the watched inputs are quiet
`timescale 1ns/1ps
`default_nettype none
`include "pse_map_defines.vh"
module pse_map_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic map_locked_ff,
  input wire logic four_pair_quad_ff,
  input wire logic [2:0] cfg_code_ff,
  input wire logic [5:0] chan_count_ff,
  input wire logic [5:0] port_count_ff,
  input wire logic [`QUAD_OFFSETS-1:0] quad_used_ff,
  input wire logic [7:0] rd_data_ff,
  input wire logic rd_miss_ff,
  input wire logic long_first_ff,
  input wire logic [2:0] class_ev_max_ff,
  input wire logic type34_en,
  input wire logic budget_req,
  input wire logic budget_valid_ff,
  input wire logic ac_valid,
  input wire logic [`PWR_W-1:0] ac_meas,
  input wire logic [`PWR_W-1:0] ac_max_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  pair_mode_a: assert property (map_locked_ff |-> four_pair_quad_ff == cfg_code_ff[0])
    else $error("pair mode not from code bit 0");
  map_hold_a: assert property (map_locked_ff && $past(map_locked_ff) |-> $stable(cfg_code_ff))
    else $error("captured code changed");
  quad_gap_a: assert property (1'b1 |-> (quad_used_ff & 16'h8888) == 16'h0000)
    else $error("fourth offset in use");
  chan_max_a: assert property (1'b1 |-> chan_count_ff <= 6'h30)
    else $error("channel count above limit");
  port_count_a: assert property (map_locked_ff |->
    port_count_ff == (four_pair_quad_ff ? chan_count_ff >> 1 : chan_count_ff))
    else $error("port count wrong");
  miss_zero_a: assert property (rd_miss_ff |-> rd_data_ff == 8'h00)
    else $error("refused read not zero");
  long_first_a: assert property ($changed(type34_en) |=> long_first_ff == $past(type34_en))
    else $error("long first event late");
  class_ev_a: assert property (1'b1 |-> class_ev_max_ff == (long_first_ff ? 3'h5 : 3'h2))
    else $error("class event limit wrong");
  budget_done_a: assert property (budget_valid_ff |-> $past(budget_req))
    else $error("budget result without request");
  ac_take_a: assert property ($past(ac_valid) |-> ac_max_ff == $past(ac_meas))
    else $error("measured maximum not taken");
endmodule
bind pse_port_config_map pse_map_monitor u_mon (.sys_clk, .rst_n, .map_locked_ff, .four_pair_quad_ff,
  .cfg_code_ff, .chan_count_ff, .port_count_ff, .quad_used_ff, .rd_data_ff, .rd_miss_ff, .long_first_ff,
  .class_ev_max_ff, .type34_en, .budget_req, .budget_valid_ff, .ac_valid, .ac_meas, .ac_max_ff);
`default_nettype wire

/* File: verif/host_model.sv */
// host side model issuing slice requests
// assumes the map block shares sys_clk
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  output logic [2:0] kind,
  output logic [3:0] slice_quad,
  output logic [1:0] slice_port,
  output logic [1:0] slice_sel,
  output logic [7:0] slice_wdata
);
  initial {kind, slice_quad, slice_port, slice_sel, slice_wdata} = 19'h0;
  // kind bits are pushbutton, read, write; fields are driven inverted once released
  task op(input logic [2:0] k, input logic [3:0] q, input logic [1:0] p, s, input logic [7:0] d);
    @(posedge sys_clk);
    {kind, slice_quad, slice_port, slice_sel, slice_wdata} <= {k, q, p, s, d};
    @(posedge sys_clk);
    {kind, slice_quad, slice_port, slice_sel, slice_wdata} <= {3'h0, ~q, ~p, ~s, ~d};
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_pse_port_config_map.sv */
// self-checking bench for the port map block
// assumes a 50 MHz sys_clk and the host model
`timescale 1ns/1ps
`default_nettype none
`include "pse_map_defines.vh"
module tb_pse_port_config_map;
  logic sys_clk = 0, rst_n = 0, type34_en = 0, budget_req = 0, budget_dual = 0, ac_valid = 0, clk_en = 1;
  logic [2:0] cfg_pin = 3'h0;
  logic [3:0] dev_present = 4'h0, dev_large = 4'h0, class_a = 4'h0, class_b = 4'h0;
  logic [47:0] chan_pwr_good = 48'h0;
  logic [10:0] ac_meas = 11'h000;
  wire [2:0] kind, cfg_code_ff, dev_count_ff, class_ev_max_ff;
  wire [3:0] slice_quad;
  wire [1:0] slice_port, slice_sel;
  wire [7:0] slice_wdata, rd_data_ff;
  wire map_locked_ff, four_pair_quad_ff, cfg_err_ff, rd_valid_ff, rd_miss_ff, long_first_ff, budget_valid_ff;
  wire [5:0] chan_count_ff, port_count_ff;
  wire [15:0] quad_used_ff;
  wire [383:0] chan_ctl_ff;
  wire [47:0] pb_on_ff;
  wire [10:0] budget_ff, ac_max_ff, ac_reclaim_ff;
  wire [31:0] map_seen = {cfg_code_ff, four_pair_quad_ff, chan_count_ff, port_count_ff, quad_used_ff};
  int err_total = 0, check_count = 0;
  logic [39:0] rows [5] = '{{3'h0, 4'h1, 4'h1, 1'h0, 6'h0c, 6'h0c, 16'h0007},
    {3'h3, 4'h3, 4'h0, 1'h1, 6'h10, 6'h08, 16'h0003}, {3'h5, 4'h7, 4'h3, 1'h1, 6'h20, 6'h10, 16'h0017},
    {3'h6, 4'hf, 4'h7, 1'h0, 6'h2c, 6'h2c, 16'h3777}, {3'h7, 4'hf, 4'hf, 1'h1, 6'h30, 6'h18, 16'h0077}};
  logic [10:0] pw [8] = '{11'h028, 11'h043, 11'h08c, 11'h12c, 11'h1c2, 11'h258, 11'h2ee, 11'h384};
  initial forever #10 sys_clk = ~sys_clk;
  host_model hm (.sys_clk, .kind, .slice_quad, .slice_port, .slice_sel, .slice_wdata);
  pse_port_config_map dut (.sys_clk, .rst_n, .clk_en, .cfg_pin, .dev_present, .dev_large,
    .slice_wr(kind[0]), .slice_rd(kind[1]), .slice_pb(kind[2]), .slice_quad, .slice_port, .slice_sel,
    .slice_wdata, .chan_pwr_good, .type34_en, .budget_req, .budget_dual, .class_a, .class_b, .ac_valid,
    .ac_meas, .map_locked_ff, .four_pair_quad_ff, .cfg_code_ff, .dev_count_ff, .chan_count_ff, .port_count_ff,
    .quad_used_ff, .cfg_err_ff, .rd_data_ff, .rd_valid_ff, .rd_miss_ff, .chan_ctl_ff, .pb_on_ff, .long_first_ff,
    .class_ev_max_ff, .budget_ff, .budget_valid_ff, .ac_max_ff, .ac_reclaim_ff);
  task chk(input logic [63:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // strap and devices only count at capture, so each row needs a reset
  task boot(input logic [2:0] c, input logic [3:0] p, l);
    int n;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    {cfg_pin, dev_present, dev_large} <= {c, p, l};
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (n = 0; n < 20 && map_locked_ff !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 20) begin
      err_total++;
      complete_run;
    end
  endtask
  task bud(input logic [3:0] a, b, input logic d);
    @(posedge sys_clk);
    {budget_req, class_a, class_b, budget_dual} <= {1'b1, a, b, d};
    @(posedge sys_clk);
    budget_req <= 1'b0;
    #1;
  endtask
  initial begin
    for (int i = 0; i < 5; i++) begin
      boot(rows[i][39:37], rows[i][36:33], rows[i][32:29]);
      chk(map_seen, {rows[i][39:37], rows[i][28:0]});
      chk({cfg_err_ff, dev_count_ff}, {1'b0, 3'($countones(rows[i][36:33]))});
      $display("row %0d done", i);
    end
    @(posedge sys_clk) cfg_pin <= 3'h0;
    repeat (6) @(posedge sys_clk);
    #1 chk({cfg_code_ff, four_pair_quad_ff}, {3'h7, 1'b1});
    @(posedge sys_clk) chan_pwr_good <= 48'h0800_0000;
    hm.op(3'h1, 4'h4, 2'h1, 2'h0, 8'h12);
    #1 chk(chan_ctl_ff[223:208], 16'h1212);
    hm.op(3'h1, 4'h4, 2'h1, 2'h2, 8'h56);
    #1 chk(chan_ctl_ff[223:208], 16'h5612);
    hm.op(3'h2, 4'h4, 2'h1, 2'h2, 8'h00);
    #1 chk({rd_valid_ff, rd_data_ff}, 9'h1d6);
    hm.op(3'h4, 4'h4, 2'h1, 2'h2, 8'h00);
    #1 chk(pb_on_ff, 48'h0800_0000);
    $display("four pair done");
    boot(3'h6, 4'hf, 4'hf);
    @(posedge sys_clk) chan_pwr_good <= 48'h40;
    hm.op(3'h1, 4'h1, 2'h2, 2'h1, 8'h35);
    hm.op(3'h1, 4'h1, 2'h2, 2'h2, 8'h7f);
    #1 chk(chan_ctl_ff[63:48], 16'h0035);
    hm.op(3'h2, 4'h1, 2'h2, 2'h1, 8'h00);
    #1 chk({rd_valid_ff, rd_data_ff}, 9'h1b5);
    hm.op(3'h2, 4'h3, 2'h0, 2'h1, 8'h00);
    #1 chk({rd_miss_ff, rd_data_ff}, 9'h100);
    hm.op(3'h4, 4'h1, 2'h2, 2'h1, 8'h00);
    #1 chk(pb_on_ff, 48'h40);
    @(posedge sys_clk) clk_en <= 1'b0;
    hm.op(3'h5, 4'h1, 2'h2, 2'h1, 8'h11);
    #1 chk({pb_on_ff, chan_ctl_ff[55:48]}, {48'h0, 8'h35});
    @(posedge sys_clk) clk_en <= 1'b1;
    $display("two pair done");
    boot(3'h2, 4'h0, 4'h0);
    hm.op(3'h2, 4'h0, 2'h0, 2'h0, 8'h00);
    #1 chk({cfg_err_ff, dev_count_ff, quad_used_ff}, {1'b1, 3'h0, 16'h0000});
    chk({rd_miss_ff, rd_data_ff}, 9'h100);
    $display("no device done");
    for (int c = 1; c < 9; c++) begin
      bud(c[3:0], 4'h0, 1'b0);
      chk({budget_valid_ff, budget_ff}, {1'b1, pw[c-1]});
    end
    bud(4'h4, 4'h5, 1'b1);
    chk(budget_ff, 11'h2ee);
    @(posedge sys_clk);
    {ac_valid, ac_meas} <= {1'b1, 11'h100};
    @(posedge sys_clk);
    ac_valid <= 1'b0;
    #1 chk({ac_max_ff, ac_reclaim_ff}, {11'h100, 11'h1ee});
    @(posedge sys_clk) type34_en <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk({long_first_ff, class_ev_max_ff}, {1'b1, 3'h5});
    $display("budget done");
    complete_run;
  end
endmodule
`default_nettype wire
